/* dtu_consts.vh */
// Purpose: constants for the dual channel dma transfer unit
// Assumes: included by dtu_top.v and the address step module
// Notes:   byte addresses on a 32-bit classic wishbone slave
//
// What this block does
// - move data between local and global addresses
// - source or sink serial or parallel devices
// - byte sizes local only, global words only
// - cpu loads chain address, unit fetches rest
// - two identical channels, shared chip-level registers
// - interleave between channels or with cpu
// - hog mode keeps bus until operation ends
// - transfer reads source then writes destination
// - search reads source, compares, never writes
// - masked bit positions ignored during compare
// - transfer-and-search stops on programmed match condition
// - base-to-current reload copies internally, no memory
// - chaining reloads registers from new table
// - on completion interrupt, reload, chain or nothing
// - master mode holds chip-level enables
// - command writes issue reset, start chain, others
// - reset clears irq flags, sets abort, clears mode
// - reload word bits 9..0 select loaded registers
// - mask bit one always counts as match
// - software start blocked by second irq or no-reload
`ifndef DTU_CONSTS_VH
`define DTU_CONSTS_VH
// register byte addresses, channel window selects on address bits 7..5
`define DTU_A_MMR     8'h00
`define DTU_A_CMD     8'h04
`define DTU_CH0_SEL   3'h1
`define DTU_CH1_SEL   3'h2
// word index inside a channel window
`define DTU_R_CHS     3'h0
`define DTU_R_CHO     3'h1
`define DTU_R_STAT    3'h2
`define DTU_R_CNT     3'h3
`define DTU_R_CML     3'h4
`define DTU_R_CMH     3'h5
`define DTU_R_IVEC    3'h6
`define DTU_R_ISAVE   3'h7
// command codes, channel select bit
`define DTU_CMD_RESET 4'h0
`define DTU_CMD_START 4'h1
`define DTU_CMD_SWSET 4'h2
`define DTU_CMD_SWCLR 4'h3
`define DTU_CMD_IACK  4'h4
`define DTU_CMD_CHB   4
// master mode bits
`define DTU_MM_EN     0
`define DTU_MM_CPUIL  1
`define DTU_MM_ASYNC  2
`define DTU_MM_CTIRQ  3
`define DTU_MM_SAVEV  4
`define DTU_MM_W      5
// segment/tag bits
`define DTU_TAG_GLB   6
`define DTU_STEP_INC  2'h0
`define DTU_STEP_DEC  2'h1
// channel mode low fields
`define DTU_OP_XFER   2'h0
`define DTU_OP_SRCH   2'h1
`define DTU_OP_XS     2'h2
`define DTU_SZ_WORD   2'h0
`define DTU_SZ_HIGH   2'h1
`define DTU_ML_ASRC   4
`define DTU_TT_HOG    2'h1
`define DTU_ML_CIRQ   7
`define DTU_ML_B2C    8
`define DTU_ML_CHN    9
// channel mode high fields
`define DTU_MC_MATCH  2'h1
`define DTU_MC_NOMAT  2'h2
`define DTU_MH_SWREQ  3
// reload word bits
`define DTU_RL_CARA   4'h9
`define DTU_RL_CARB   4'h8
`define DTU_RL_COPC   4'h7
`define DTU_RL_BARA   4'h6
`define DTU_RL_BARB   4'h5
`define DTU_RL_BOPC   4'h4
`define DTU_RL_PM     4'h3
`define DTU_RL_IVEC   4'h2
`define DTU_RL_MODE   4'h1
`define DTU_RL_CHAIN  4'h0
// engine states
`define DTU_S_IDLE    3'h0
`define DTU_S_CRD     3'h1
`define DTU_S_SRC     3'h2
`define DTU_S_DST     3'h3
`define DTU_S_CNT     3'h4
`define DTU_S_DONE    3'h5
`define DTU_S_YLD     3'h6
`endif

/* dtu_match.v */
// Purpose: pattern compare with don't-care mask
// Assumes: same-clock data
// Notes:   purely combinational
`timescale 1ns/10ps
module dtu_match #(
    parameter W = 16
) (
    // compare operands
    input  wire [W-1:0] dat_i,
    input  wire [W-1:0] pat_i,
    input  wire [W-1:0] msk_i,
    // result
    output wire         hit_o
);
    assign hit_o = ~|((dat_i ^ pat_i) & ~msk_i);
endmodule

/* dtu_addr_step.v */
// Purpose: next address for increment, decrement or hold
// Assumes: word step two, byte step one
// Notes:   purely combinational
`timescale 1ns/10ps
`include "dtu_consts.vh"
module dtu_addr_step #(
    parameter AW = 22
) (
    // current address and step
    input  wire [AW-1:0] adr_i,
    input  wire [1:0]    mode_i,
    input  wire          byte_i,
    // next address
    output wire [AW-1:0] adr_o
);
    wire [AW-1:0] d = {{(AW-2){1'b0}}, ~byte_i, byte_i};
    assign adr_o = (mode_i == `DTU_STEP_INC) ? adr_i + d :
                   (mode_i == `DTU_STEP_DEC) ? adr_i - d : adr_i;
endmodule

/* dtu_top.v */
// Purpose: two channel dma transfer unit with chain loading
// Assumes: mem_ack_i and bus_gnt_i come from logic on clk_i
// Notes:   one engine serves both channels in turn
`timescale 1ns/10ps
`include "dtu_consts.vh"
module dtu_top #(
    parameter AW = 22
) (
    // clock and reset
    input  wire          clk_i,
    input  wire          rst_i,
    // wishbone slave
    input  wire          wb_cyc_i,
    input  wire          wb_stb_i,
    input  wire          wb_we_i,
    input  wire [7:0]    wb_adr_i,
    input  wire [3:0]    wb_sel_i,
    input  wire [31:0]   wb_dat_i,
    output wire [31:0]   wb_dat_o,
    output wire          wb_ack_o,
    // memory master
    output wire          mem_req_o,
    output wire          mem_we_o,
    output wire          mem_glob_o,
    output wire [1:0]    mem_tgt_o,
    output wire [AW-1:0] mem_adr_o,
    output wire [1:0]    mem_bsel_o,
    output wire [15:0]   mem_dat_o,
    input  wire [15:0]   mem_dat_i,
    input  wire          mem_ack_i,
    // bus arbitration
    output wire          bus_req_o,
    input  wire          bus_gnt_i,
    // chip level outputs
    output wire          irq_o,
    output wire          async_en_o,
    output wire          ct_irq_en_o,
    output wire          save_vec_en_o
);
    // channel registers
    reg [15:0] cas [0:1];
    reg [15:0] cao [0:1];
    reg [15:0] cbs [0:1];
    reg [15:0] cbo [0:1];
    reg [15:0] bas [0:1];
    reg [15:0] bao [0:1];
    reg [15:0] bbs [0:1];
    reg [15:0] bbo [0:1];
    reg [15:0] copc [0:1];
    reg [15:0] bopc [0:1];
    reg [15:0] pat [0:1];
    reg [15:0] msk [0:1];
    reg [15:0] cml [0:1];
    reg [15:0] cmh [0:1];
    reg [15:0] chs [0:1];
    reg [15:0] cho [0:1];
    reg [15:0] ivec [0:1];
    reg [15:0] isv [0:1];
    reg [1:0]  cie_r, ip_r, sip_r, wfb_r, ca_r, nac_r, tc_r, mc_r, cpend_r;
    reg [`DTU_MM_W-1:0] mmr_r;
    // bus slave and engine state
    reg        ack_r;
    reg [31:0] rdat_r;
    reg [2:0]  st_r;
    reg        ch_r, rr_r, first_r, sub_r, hit_r;
    reg [9:0]  rw_r;
    reg [AW-1:0] cp_r;
    reg        cglb_r;
    reg [15:0] dat_r;
    reg        mreq_r, mwe_r, mglb_r, breq_r, irq_r;
    reg [1:0]  mtgt_r, mbsel_r;
    reg [AW-1:0] madr_r;
    reg [15:0] mdo_r;
    integer    i;
    integer    j;

    // current channel view
    wire        c = ch_r;
    wire [15:0] ml = cml[c];
    wire [15:0] mh = cmh[c];
    wire        asrc = ml[`DTU_ML_ASRC];
    wire [15:0] ssg = asrc ? cas[c] : cbs[c];
    wire [15:0] dsg = asrc ? cbs[c] : cas[c];
    wire [1:0]  op = ml[1:0];
    wire [1:0]  sz = ml[3:2];
    wire [1:0]  tt = ml[6:5];
    wire [AW-1:0] a_cur = {cas[c][5:0], cao[c]};
    wire [AW-1:0] b_cur = {cbs[c][5:0], cbo[c]};
    wire [AW-1:0] a_nxt, b_nxt;
    wire        hit;

    dtu_addr_step #(.AW(AW)) u_stepa (
        .adr_i  (a_cur),
        .mode_i (cas[c][8:7]),
        .byte_i (sz != `DTU_SZ_WORD && !cas[c][`DTU_TAG_GLB]),
        .adr_o  (a_nxt)
    );
    dtu_addr_step #(.AW(AW)) u_stepb (
        .adr_i  (b_cur),
        .mode_i (cbs[c][8:7]),
        .byte_i (sz != `DTU_SZ_WORD && !cbs[c][`DTU_TAG_GLB]),
        .adr_o  (b_nxt)
    );
    dtu_match #(.W(16)) u_match (
        .dat_i (mem_dat_i),
        .pat_i (pat[c]),
        .msk_i (msk[c]),
        .hit_o (hit)
    );

    // lane select: global side always a full word
    function [1:0] lanes;
        input [1:0] s;
        input       g;
        begin
            if (g || s == `DTU_SZ_WORD)
                lanes = 2'h3;
            else if (s == `DTU_SZ_HIGH)
                lanes = 2'h2;
            else
                lanes = 2'h1;
        end
    endfunction

    // highest pending reload bit
    reg [3:0] hb;
    always @* begin
        hb = 4'h0;
        for (j = 0; j < 10; j = j + 1)
            if (rw_r[j])
                hb = j[3:0];
    end
    wire two = (hb != `DTU_RL_COPC) && (hb != `DTU_RL_BOPC) && (hb != `DTU_RL_IVEC);

    // channel readiness and pick
    wire [1:0] run = {cmh[1][`DTU_MH_SWREQ] & ~sip_r[1] & ~nac_r[1],
                      cmh[0][`DTU_MH_SWREQ] & ~sip_r[0] & ~nac_r[0]};
    wire [1:0] rdy = (cpend_r | run) & {2{mmr_r[`DTU_MM_EN]}};
    wire       pick = rdy[rr_r] ? rr_r : ~rr_r;
    wire       last = (copc[c] == 16'h1);
    wire       mcond = (op != `DTU_OP_XFER) &&
                       ((mh[1:0] == `DTU_MC_MATCH && hit_r) ||
                        (mh[1:0] == `DTU_MC_NOMAT && !hit_r));

    // wishbone decode
    wire        wb_hit = wb_cyc_i & wb_stb_i & ~ack_r;
    wire        wr = wb_hit & wb_we_i;
    wire [2:0]  wsel = wb_adr_i[7:5];
    wire        wch = (wsel == `DTU_CH1_SEL);
    wire        wchv = (wsel == `DTU_CH0_SEL) || (wsel == `DTU_CH1_SEL);
    wire [2:0]  widx = wb_adr_i[4:2];
    wire [15:0] wm = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire [15:0] wv = wb_dat_i[15:0] & wm;
    wire        cmd_v = wr && wb_adr_i == `DTU_A_CMD && wb_sel_i[0];
    wire [3:0]  cmd = wb_dat_i[3:0];
    wire        cch = wb_dat_i[`DTU_CMD_CHB];
    wire        cmd_rst = cmd_v && cmd == `DTU_CMD_RESET;
    reg  [15:0] rmux;
    always @* begin
        rmux = 16'h0;
        if (wb_adr_i == `DTU_A_MMR)
            rmux = {{(16-`DTU_MM_W){1'b0}}, mmr_r};
        else if (wchv) begin
            case (widx)
                `DTU_R_CHS:   rmux = chs[wch];
                `DTU_R_CHO:   rmux = cho[wch];
                `DTU_R_STAT:  rmux = {7'h0, st_r != `DTU_S_IDLE && ch_r == wch, mc_r[wch],
                                      tc_r[wch], nac_r[wch], ca_r[wch], wfb_r[wch],
                                      sip_r[wch], ip_r[wch], cie_r[wch]};
                `DTU_R_CNT:   rmux = copc[wch];
                `DTU_R_CML:   rmux = cml[wch];
                `DTU_R_CMH:   rmux = cmh[wch];
                `DTU_R_IVEC:  rmux = ivec[wch];
                default:      rmux = isv[wch];
            endcase
        end
    end

    always @(posedge clk_i) begin
        if (rst_i || cmd_rst) begin
            // chip reset: both channels to a known state
            cie_r   <= 2'h0;
            ip_r    <= 2'h0;
            sip_r   <= 2'h0;
            wfb_r   <= 2'h0;
            ca_r    <= 2'h3;
            nac_r   <= 2'h3;
            mmr_r   <= {`DTU_MM_W{1'b0}};
            cpend_r <= 2'h0;
            tc_r    <= 2'h0;
            mc_r    <= 2'h0;
            st_r    <= `DTU_S_IDLE;
            mreq_r  <= 1'b0;
            breq_r  <= 1'b0;
            irq_r   <= 1'b0;
            ch_r    <= 1'b0;
            rr_r    <= 1'b0;
            for (i = 0; i < 2; i = i + 1) begin
                cml[i] <= 16'h0;
                cmh[i] <= 16'h0;
            end
        end else begin
            irq_r  <= |(ip_r & cie_r);
            wfb_r  <= {2{breq_r & ~bus_gnt_i}} & {ch_r, ~ch_r};
            // register writes
            if (wr && wb_adr_i == `DTU_A_MMR)
                mmr_r <= (mmr_r & ~wm[`DTU_MM_W-1:0]) | wv[`DTU_MM_W-1:0];
            if (wr && wchv) begin
                case (widx)
                    `DTU_R_CHS: begin
                        chs[wch] <= (chs[wch] & ~wm) | wv;
                        ca_r[wch] <= 1'b0;
                    end
                    `DTU_R_CHO: begin
                        cho[wch] <= (cho[wch] & ~wm) | wv;
                        ca_r[wch] <= 1'b0;
                    end
                    `DTU_R_CML: begin
                        cml[wch] <= (cml[wch] & ~wm) | wv;
                        cie_r[wch] <= wb_sel_i[0] ? wb_dat_i[`DTU_ML_CIRQ] : cie_r[wch];
                    end
                    `DTU_R_CMH:  cmh[wch] <= (cmh[wch] & ~wm) | wv;
                    `DTU_R_IVEC: ivec[wch] <= (ivec[wch] & ~wm) | wv;
                    default: ;
                endcase
            end
            // channel commands
            if (cmd_v) begin
                case (cmd)
                    `DTU_CMD_START: begin
                        nac_r[cch] <= 1'b0;
                        if (!sip_r[cch] && !ca_r[cch])
                            cpend_r[cch] <= 1'b1;
                    end
                    `DTU_CMD_SWSET: cmh[cch][`DTU_MH_SWREQ] <= 1'b1;
                    `DTU_CMD_SWCLR: cmh[cch][`DTU_MH_SWREQ] <= 1'b0;
                    `DTU_CMD_IACK: begin
                        if (sip_r[cch])
                            sip_r[cch] <= 1'b0;
                        else
                            ip_r[cch] <= 1'b0;
                    end
                    default: ;
                endcase
            end
            // engine; its flag sets come last so they win over clears
            case (st_r)
                `DTU_S_IDLE: begin
                    breq_r <= |rdy;
                    if (|rdy && breq_r && bus_gnt_i) begin
                        ch_r <= pick;
                        rr_r <= ~pick;
                        if (cpend_r[pick]) begin
                            cpend_r[pick] <= 1'b0;
                            cp_r    <= {chs[pick][5:0], cho[pick]};
                            cglb_r  <= chs[pick][`DTU_TAG_GLB];
                            first_r <= 1'b1;
                            sub_r   <= 1'b0;
                            st_r    <= `DTU_S_CRD;
                        end else begin
                            st_r <= `DTU_S_SRC;
                        end
                    end
                end
                `DTU_S_CRD: begin
                    if (!mreq_r) begin
                        if (!first_r && rw_r == 10'h0)
                            st_r <= mh[`DTU_MH_SWREQ] ? `DTU_S_SRC : `DTU_S_IDLE;
                        else if (bus_gnt_i) begin
                            mreq_r  <= 1'b1;
                            mwe_r   <= 1'b0;
                            madr_r  <= cp_r;
                            mglb_r  <= cglb_r;
                            mtgt_r  <= 2'h0;
                            mbsel_r <= 2'h3;
                        end
                    end else if (mem_ack_i) begin
                        mreq_r <= 1'b0;
                        cp_r   <= cp_r + {{(AW-2){1'b0}}, 2'h2};
                        first_r <= 1'b0;
                        if (first_r)
                            rw_r <= mem_dat_i[9:0];
                        else begin
                            sub_r <= two & ~sub_r;
                            if (!two || sub_r)
                                rw_r[hb] <= 1'b0;
                            case (hb)
                                `DTU_RL_CARA: if (sub_r) cao[c] <= mem_dat_i;
                                              else cas[c] <= mem_dat_i;
                                `DTU_RL_CARB: if (sub_r) cbo[c] <= mem_dat_i;
                                              else cbs[c] <= mem_dat_i;
                                `DTU_RL_COPC: copc[c] <= mem_dat_i;
                                `DTU_RL_BARA: if (sub_r) bao[c] <= mem_dat_i;
                                              else bas[c] <= mem_dat_i;
                                `DTU_RL_BARB: if (sub_r) bbo[c] <= mem_dat_i;
                                              else bbs[c] <= mem_dat_i;
                                `DTU_RL_BOPC: bopc[c] <= mem_dat_i;
                                `DTU_RL_PM:   if (sub_r) msk[c] <= mem_dat_i;
                                              else pat[c] <= mem_dat_i;
                                `DTU_RL_IVEC: ivec[c] <= mem_dat_i;
                                `DTU_RL_MODE: if (sub_r) begin
                                                  cml[c] <= mem_dat_i;
                                                  cie_r[c] <= mem_dat_i[`DTU_ML_CIRQ];
                                              end else cmh[c] <= mem_dat_i;
                                default: begin
                                    if (sub_r) begin
                                        cho[c] <= mem_dat_i;
                                        ca_r[c] <= 1'b0;
                                    end else chs[c] <= mem_dat_i;
                                end
                            endcase
                        end
                    end
                end
                `DTU_S_SRC: begin
                    if (!mreq_r) begin
                        if (bus_gnt_i) begin
                            mreq_r  <= 1'b1;
                            mwe_r   <= 1'b0;
                            madr_r  <= asrc ? a_cur : b_cur;
                            mglb_r  <= ssg[`DTU_TAG_GLB];
                            mtgt_r  <= ssg[10:9];
                            mbsel_r <= lanes(sz, ssg[`DTU_TAG_GLB]);
                        end
                    end else if (mem_ack_i) begin
                        mreq_r <= 1'b0;
                        dat_r  <= mem_dat_i;
                        hit_r  <= hit;
                        if (asrc) begin
                            cas[c][5:0] <= a_nxt[AW-1:16];
                            cao[c] <= a_nxt[15:0];
                        end else begin
                            cbs[c][5:0] <= b_nxt[AW-1:16];
                            cbo[c] <= b_nxt[15:0];
                        end
                        st_r <= (op == `DTU_OP_SRCH) ? `DTU_S_CNT : `DTU_S_DST;
                    end
                end
                `DTU_S_DST: begin
                    if (!mreq_r) begin
                        if (bus_gnt_i) begin
                            mreq_r  <= 1'b1;
                            mwe_r   <= 1'b1;
                            madr_r  <= asrc ? b_cur : a_cur;
                            mglb_r  <= dsg[`DTU_TAG_GLB];
                            mtgt_r  <= dsg[10:9];
                            mbsel_r <= lanes(sz, dsg[`DTU_TAG_GLB]);
                            mdo_r   <= dat_r;
                        end
                    end else if (mem_ack_i) begin
                        mreq_r <= 1'b0;
                        if (asrc) begin
                            cbs[c][5:0] <= b_nxt[AW-1:16];
                            cbo[c] <= b_nxt[15:0];
                        end else begin
                            cas[c][5:0] <= a_nxt[AW-1:16];
                            cao[c] <= a_nxt[15:0];
                        end
                        st_r <= `DTU_S_CNT;
                    end
                end
                `DTU_S_CNT: begin
                    copc[c] <= copc[c] - 16'h1;
                    if (last || mcond) begin
                        tc_r[c] <= last;
                        mc_r[c] <= mcond;
                        st_r <= `DTU_S_DONE;
                    end else if (tt == `DTU_TT_HOG)
                        st_r <= `DTU_S_SRC;
                    else if (mmr_r[`DTU_MM_CPUIL])
                        st_r <= `DTU_S_YLD;
                    else
                        st_r <= `DTU_S_IDLE;
                end
                `DTU_S_DONE: begin
                    if (ml[`DTU_ML_CIRQ]) begin
                        if (ip_r[c])
                            sip_r[c] <= 1'b1;
                        else
                            ip_r[c] <= 1'b1;
                        if (mmr_r[`DTU_MM_SAVEV])
                            isv[c] <= ivec[c];
                    end
                    if (ml[`DTU_ML_B2C]) begin
                        cas[c]  <= bas[c];
                        cao[c]  <= bao[c];
                        cbs[c]  <= bbs[c];
                        cbo[c]  <= bbo[c];
                        copc[c] <= bopc[c];
                    end
                    if (ml[`DTU_ML_CHN]) begin
                        cp_r    <= {chs[c][5:0], cho[c]};
                        cglb_r  <= chs[c][`DTU_TAG_GLB];
                        first_r <= 1'b1;
                        sub_r   <= 1'b0;
                        st_r    <= `DTU_S_CRD;
                    end else begin
                        if (!ml[`DTU_ML_B2C]) begin
                            cmh[c][`DTU_MH_SWREQ] <= 1'b0;
                            nac_r[c] <= 1'b1;
                        end
                        st_r <= `DTU_S_YLD;
                    end
                end
                `DTU_S_YLD: begin
                    breq_r <= 1'b0;
                    st_r   <= `DTU_S_IDLE;
                end
                default: st_r <= `DTU_S_IDLE;
            endcase
        end
    end

    // bus slave handshake and read data
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h0;
        end else begin
            ack_r <= wb_hit;
            if (wb_hit)
                rdat_r <= {16'h0, rmux};
        end
    end

    assign wb_ack_o      = ack_r;
    assign wb_dat_o      = rdat_r;
    assign mem_req_o     = mreq_r;
    assign mem_we_o      = mwe_r;
    assign mem_glob_o    = mglb_r;
    assign mem_tgt_o     = mtgt_r;
    assign mem_adr_o     = madr_r;
    assign mem_bsel_o    = mbsel_r;
    assign mem_dat_o     = mdo_r;
    assign bus_req_o     = breq_r;
    assign irq_o         = irq_r;
    assign async_en_o    = mmr_r[`DTU_MM_ASYNC];
    assign ct_irq_en_o   = mmr_r[`DTU_MM_CTIRQ];
    assign save_vec_en_o = mmr_r[`DTU_MM_SAVEV];
endmodule

/* dtu_chk.sv */
// Purpose: port checker for dtu_top
// Assumes: one clock, synchronous reset
// Notes:   bound into dtu_top
`timescale 1ns/10ps
module dtu_chk #(parameter AW = 22) (
    input wire clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire mem_req_o, mem_we_o, mem_glob_o, mem_ack_i, bus_req_o,
    input wire [AW-1:0] mem_adr_o,
    input wire [1:0] mem_bsel_o,
    input wire irq_o, async_en_o, ct_irq_en_o, save_vec_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("register access not answered");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_mode_load: assert property (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
        && wb_adr_i == 8'h00 && wb_sel_i[0] |-> ##2
        {save_vec_en_o, ct_irq_en_o, async_en_o} == $past(wb_dat_i[4:2], 2))
        else $error("mode bits not loaded");
    a_reset_clear: assert property ($fell(rst_i) |->
        !irq_o && !async_en_o && !ct_irq_en_o && !save_vec_en_o)
        else $error("mode not cleared by reset");
    a_req_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o
        && $stable(mem_adr_o) && $stable(mem_we_o)) else $error("request changed");
    a_req_end: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
        else $error("request kept after ack");
    a_glob_word: assert property (mem_req_o && mem_glob_o |-> mem_bsel_o == 2'h3)
        else $error("byte access on global bus");
    a_req_bus: assert property ($rose(mem_req_o) |-> bus_req_o)
        else $error("cycle without bus request");
endmodule
bind dtu_top dtu_chk #(.AW(AW)) u_chk (.*);

/* dtu_mem_mdl.sv */
// Purpose: memory and arbiter at the far side
// Assumes: word accesses, 1k words
// Notes:   random grant and ack delays
`timescale 1ns/10ps
module dtu_mem_mdl (
    input wire clk_i, req_i, we_i, breq_i,
    input wire [21:0] adr_i,
    input wire [15:0] dat_i,
    output reg [15:0] dat_o = 16'h0,
    output reg ack_o = 1'b0,
    output reg gnt_o = 1'b0
);
    reg [15:0] mem [0:1023]; // chain tables and data
    always @(posedge clk_i) begin
        gnt_o <= breq_i && ($urandom % 4 != 0);
        ack_o <= 1'b0;
        dat_o <= ~dat_o;
        if (req_i && !ack_o && ($urandom % 3 == 0)) begin
            ack_o <= 1'b1;
            if (we_i) mem[adr_i[10:1]] <= dat_i;
            else dat_o <= mem[adr_i[10:1]];
        end
    end
endmodule

/* test_dtu_top.sv */
// Purpose: self-checking bench for dtu_top
// Assumes: word transfers, local except one global destination
// Notes:   reads noted in a queue
`timescale 1ns/10ps
`define CMP(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module test_dtu_top;
    reg clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    reg [7:0] adr = 0;
    reg [15:0] wd = 0, t, sa [0:7], sb [0:7];
    reg [16:0] q [$], n;
    wire [31:0] rdat;
    wire ack, mreq, mwe, breq, gnt, mack, irq;
    wire [21:0] madr;
    wire [15:0] mdo, mdi;
    integer fails = 0, n_compared = 0, i, p, nreq = 0;
    always #50 clk_i = ~clk_i;
    dtu_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i({16'h0, wd}),
        .wb_dat_o(rdat), .wb_ack_o(ack), .mem_req_o(mreq), .mem_we_o(mwe),
        .mem_glob_o(), .mem_tgt_o(), .mem_adr_o(madr), .mem_bsel_o(),
        .mem_dat_o(mdo), .mem_dat_i(mdi), .mem_ack_i(mack), .bus_req_o(breq),
        .bus_gnt_i(gnt), .irq_o(irq), .async_en_o(), .ct_irq_en_o(), .save_vec_en_o());
    dtu_mem_mdl mdl (.clk_i(clk_i), .req_i(mreq), .we_i(mwe), .breq_i(breq),
        .adr_i(madr), .dat_i(mdo), .dat_o(mdi), .ack_o(mack), .gnt_o(gnt));
    task close_out;
        $display("fails=%0d n_compared=%0d", fails, n_compared);
        if (fails == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task wb(input [7:0] a, input w, input [15:0] d);
        @(posedge clk_i);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wd <= d;
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        cyc <= 0; stb <= 0;
    endtask
    task rd(input [7:0] a, input [15:0] e, input c);
        q.push_back({c, e});
        wb(a, 1'b0, 16'h0);
    endtask
    task put(input [15:0] v);
        mdl.mem[p] = v; p = p + 1;
    endtask
    task go(input [15:0] off);
        wb(8'h20, 1, 16'h0); wb(8'h24, 1, off); wb(8'h04, 1, 16'h0001);
        t = 0;
        for (i = 0; i < 300 && !(t[5] && !t[8]); i++) begin
            rd(8'h28, 16'h0, 0); t = rdat[15:0];
        end
        `CMP(t[5] && !t[8], 1'b1)
    endtask
    always @(posedge clk_i) begin
        if (mreq && mack) nreq++;
        if (ack === 1'b1 && !we && q.size() > 0) begin
            n = q.pop_front();
            if (n[16]) `CMP(rdat[15:0], n[15:0])
        end
    end
    initial begin #3000000; fails++; close_out; end
    initial begin
        i = $urandom(32'he7f4e42c);
        for (i = 0; i < 8; i++) begin
            sa[i] = $urandom; t = $urandom;
            sb[i] = {t[15:8], (i == 2) ? 8'ha5 : 8'h3c};
            mdl.mem[16'h100 + i] = sa[i]; mdl.mem[16'h110 + i] = sb[i];
        end
        mdl.mem[16'h193] = 16'h0bad;
        p = 16'h80;
        put(16'h0382); put(0); put(16'h0200); put(0); put(16'h0300); put(4);
        put(16'h0008); put(16'h0010);
        p = 16'ha0;
        put(16'h038a); put(0); put(16'h0220); put(0); put(16'h0320); put(8);
        put(16'h00a5); put(16'hff00); put(16'h0009); put(16'h0012);
        p = 16'hc0;
        put(16'h0382); put(0); put(16'h0200); put(16'h0040); put(16'h03a0); put(2);
        put(16'h0008); put(16'h00b0);
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        rd(8'h28, 16'h0030, 1);
        rd(8'h48, 16'h0030, 1);
        wb(8'h00, 1, 16'h001d);
        rd(8'h00, 16'h001d, 1);
        rd(8'h80, 16'h0, 1);
        wb(8'h04, 1, 16'h0002);
        repeat (20) @(posedge clk_i);
        `CMP(nreq, 0)
        go(16'h0100);
        `CMP(nreq, 16)
        for (i = 0; i < 4; i++) `CMP(mdl.mem[16'h180 + i], sa[i])
        go(16'h0140);
        `CMP(t[7], 1'b1)
        `CMP(nreq, 32)
        for (i = 0; i < 3; i++) `CMP(mdl.mem[16'h190 + i], sb[i])
        `CMP(mdl.mem[16'h193], 16'h0bad)
        go(16'h0180);
        `CMP(irq, 1'b1)
        `CMP(nreq, 44)
        for (i = 0; i < 2; i++) `CMP(mdl.mem[16'h1d0 + i], sa[i])
        wb(8'h04, 1, 16'h0004);
        repeat (2) @(posedge clk_i);
        `CMP(irq, 1'b0)
        wb(8'h04, 1, 16'h0000);
        rd(8'h28, 16'h0030, 1);
        rd(8'h00, 16'h0000, 1);
        repeat (2) @(posedge clk_i);
        close_out;
    end
endmodule
